// ==== hdl/sdcr_params.svh ====
// offsets, field positions and reset values of the configuration and trigger registers
`ifndef SDCR_PARAMS_SVH
`define SDCR_PARAMS_SVH
`define SDCR_ADDR_NOOP 8'h00
`define SDCR_ADDR_CH1 8'h03
`define SDCR_ADDR_CH0 8'h15
`define SDCR_ADDR_SHARED_CFG 8'h1f
`define SDCR_ADDR_TRIGGER 8'h20
`define SDCR_RST_NOOP 16'h0000
`define SDCR_RST_CH 16'h0000
`define SDCR_RST_SHARED_CFG 16'h0fff
`define SDCR_RST_TRIGGER 16'h0000
`define SDCR_CH_GAIN_HI 12
`define SDCR_CH_GAIN_LO 10
`define SDCR_CH_OPENDRAIN 4
`define SDCR_CH_ROUTE 3
`define SDCR_CH_DIVIDER 2
`define SDCR_CH_INVERT 1
`define SDCR_CH_MODE_ON 0
`define SDCR_CH_MASK 16'h1c1f
`define SDCR_GAIN_MAX 3'h5
`define SDCR_CFG_LOCK 14
`define SDCR_CFG_INTREF 12
`define SDCR_CFG_PD0_HI 11
`define SDCR_CFG_PD0_LO 10
`define SDCR_CFG_PD1_HI 2
`define SDCR_CFG_PD1_LO 1
`define SDCR_CFG_FIXED 16'h03f9
`define SDCR_PD_RESET 2'h3
`define SDCR_TRG_UNLOCK_HI 15
`define SDCR_TRG_UNLOCK_LO 12
`define SDCR_TRG_SRST_HI 11
`define SDCR_TRG_SRST_LO 8
`define SDCR_TRG_STORE 1
`define SDCR_TRG_RESTORE 0
`define SDCR_UNLOCK_CODE 4'h5
`define SDCR_SRST_CODE 4'ha
`endif

// ==== hdl/sdcr_pkg.sv ====
// types shared by the configuration and trigger register bank
package sdcr_pkg;
   typedef enum logic [1:0] {
      SDCR_RD_IDLE = 2'b00,
      SDCR_RD_MSB = 2'b01,
      SDCR_RD_LSB = 2'b10
   } sdcr_rd_state_t;
   typedef logic [15:0] sdcr_word_t;
endpackage : sdcr_pkg

// ==== hdl/sdcr_channel_cfg.sv ====
// one channel output and comparator configuration register
`timescale 1ns/100ps
`include "sdcr_params.svh"
module sdcr_channel_cfg
   import sdcr_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic soft_rst,
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic load_en,
   input wire logic [DATA_W-1:0] load_data,
   output logic [DATA_W-1:0] cfg,
   output logic [2:0] output_scale_select,
   output logic comparator_pin_opendrain,
   output logic comparator_pin_route,
   output logic trigger_input_divider_select,
   output logic comparator_polarity_invert,
   output logic comparator_mode_on,
   output logic gain_code_invalid
);
   logic [DATA_W-1:0] next_cfg;

   initial begin
      if (DATA_W != 16) begin
         $error("sdcr_channel_cfg serves 16-bit registers only");
      end
   end

   // don't-care bits are not stored and read back as zero
   always_comb begin
      next_cfg = cfg;
      if (load_en) begin
         next_cfg = load_data & `SDCR_CH_MASK;
      end else if (wr_en) begin
         next_cfg = wdata & `SDCR_CH_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg <= `SDCR_RST_CH;
      end else if (soft_rst) begin
         cfg <= `SDCR_RST_CH;
      end else begin
         cfg <= next_cfg;
      end
   end

   // decoded controls kept in their own flops so they follow cfg exactly
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         output_scale_select <= 3'h0;
         comparator_pin_opendrain <= 1'b0;
         comparator_pin_route <= 1'b0;
         trigger_input_divider_select <= 1'b0;
         comparator_polarity_invert <= 1'b0;
         comparator_mode_on <= 1'b0;
         gain_code_invalid <= 1'b0;
      end else if (soft_rst) begin
         output_scale_select <= 3'h0;
         comparator_pin_opendrain <= 1'b0;
         comparator_pin_route <= 1'b0;
         trigger_input_divider_select <= 1'b0;
         comparator_polarity_invert <= 1'b0;
         comparator_mode_on <= 1'b0;
         gain_code_invalid <= 1'b0;
      end else begin
         output_scale_select <= next_cfg[`SDCR_CH_GAIN_HI:`SDCR_CH_GAIN_LO];
         gain_code_invalid <= next_cfg[`SDCR_CH_GAIN_HI:`SDCR_CH_GAIN_LO] > `SDCR_GAIN_MAX;
         comparator_pin_opendrain <= next_cfg[`SDCR_CH_OPENDRAIN] & next_cfg[`SDCR_CH_ROUTE]
            & next_cfg[`SDCR_CH_MODE_ON];
         comparator_pin_route <= next_cfg[`SDCR_CH_ROUTE];
         trigger_input_divider_select <= next_cfg[`SDCR_CH_DIVIDER];
         comparator_polarity_invert <= next_cfg[`SDCR_CH_INVERT];
         comparator_mode_on <= next_cfg[`SDCR_CH_MODE_ON];
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   opendrain_needs_mode_a: assert property (comparator_pin_opendrain |->
      cfg[`SDCR_CH_MODE_ON] && cfg[`SDCR_CH_ROUTE] && cfg[`SDCR_CH_OPENDRAIN])
      else $error("open-drain set without comparator mode and routing");
   gain_invalid_flag_a: assert property (gain_code_invalid ==
      (output_scale_select > `SDCR_GAIN_MAX))
      else $error("invalid gain flag disagrees with gain code");
   route_follows_write_a: assert property (wr_en && !load_en && !soft_rst |=>
      comparator_pin_route == $past(wdata[`SDCR_CH_ROUTE]))
      else $error("route bit did not follow the write");
   invert_follows_cfg_a: assert property (comparator_polarity_invert == cfg[`SDCR_CH_INVERT]
      && trigger_input_divider_select == cfg[`SDCR_CH_DIVIDER])
      else $error("invert or divider control differs from register");
endmodule : sdcr_channel_cfg

// ==== hdl/sdcr_top.sv ====
// configuration and trigger register bank of a two-channel smart converter
`timescale 1ns/100ps
`include "sdcr_params.svh"
module sdcr_top
   import sdcr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_addr,
   input wire logic [15:0] cmd_wdata,
   output logic rd_valid,
   output logic rd_last,
   output logic [7:0] rd_byte,
   output logic [1:0][2:0] output_scale_select,
   output logic [1:0] comparator_pin_opendrain,
   output logic [1:0] comparator_pin_route,
   output logic [1:0] trigger_input_divider_select,
   output logic [1:0] comparator_polarity_invert,
   output logic [1:0] comparator_mode_on,
   output logic [1:0] gain_code_invalid,
   output logic [1:0][1:0] channel_powerdown_select,
   output logic internal_ref_on,
   output logic register_write_lock,
   output logic soft_reset_pulse,
   output logic store_settings_pulse,
   output logic restore_settings_pulse
);
   sdcr_word_t noop_reg;
   sdcr_word_t ch_cfg [2];
   sdcr_word_t nvm_ch [2];
   sdcr_word_t nvm_shared;
   sdcr_word_t shared_rd;
   sdcr_word_t trig_rd;
   sdcr_word_t rd_word;
   logic [3:0] unlock_password_field;
   logic unlock_armed;
   logic store_settings_trigger;
   logic restore_settings_trigger;
   logic soft_rst;
   logic wr_ok;
   logic wr_trig;
   logic wr_shared;
   sdcr_rd_state_t rd_state;

   // a locked bank only listens to the trigger's password field and to the lock bit itself
   assign wr_ok = cmd_wr && !register_write_lock;
   assign wr_trig = cmd_wr && cmd_addr == `SDCR_ADDR_TRIGGER;
   assign wr_shared = cmd_wr && cmd_addr == `SDCR_ADDR_SHARED_CFG;
   assign soft_rst = soft_reset_pulse;

   // no-operation register: stored for read-back only
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         noop_reg <= `SDCR_RST_NOOP;
      end else if (soft_rst) begin
         noop_reg <= `SDCR_RST_NOOP;
      end else if (wr_ok && cmd_addr == `SDCR_ADDR_NOOP) begin
         noop_reg <= cmd_wdata;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_ch
      sdcr_channel_cfg #(.DATA_W(16)) u_ch (
         .sys_clk(sys_clk),
         .rst_b(rst_b),
         .soft_rst(soft_rst),
         .wr_en(wr_ok && cmd_addr == ((i == 0) ? `SDCR_ADDR_CH0 : `SDCR_ADDR_CH1)),
         .wdata(cmd_wdata),
         .load_en(restore_settings_trigger),
         .load_data(nvm_ch[i]),
         .cfg(ch_cfg[i]),
         .output_scale_select(output_scale_select[i]),
         .comparator_pin_opendrain(comparator_pin_opendrain[i]),
         .comparator_pin_route(comparator_pin_route[i]),
         .trigger_input_divider_select(trigger_input_divider_select[i]),
         .comparator_polarity_invert(comparator_polarity_invert[i]),
         .comparator_mode_on(comparator_mode_on[i]),
         .gain_code_invalid(gain_code_invalid[i])
      );
   end

   // shared configuration; reserved bits are fixed and not stored
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         internal_ref_on <= 1'b0;
         channel_powerdown_select <= {`SDCR_PD_RESET, `SDCR_PD_RESET};
      end else if (soft_rst) begin
         internal_ref_on <= 1'b0;
         channel_powerdown_select <= {`SDCR_PD_RESET, `SDCR_PD_RESET};
      end else if (restore_settings_trigger) begin
         internal_ref_on <= nvm_shared[`SDCR_CFG_INTREF];
         channel_powerdown_select[0] <= nvm_shared[`SDCR_CFG_PD0_HI:`SDCR_CFG_PD0_LO];
         channel_powerdown_select[1] <= nvm_shared[`SDCR_CFG_PD1_HI:`SDCR_CFG_PD1_LO];
      end else if (wr_ok && wr_shared) begin
         internal_ref_on <= cmd_wdata[`SDCR_CFG_INTREF];
         channel_powerdown_select[0] <= cmd_wdata[`SDCR_CFG_PD0_HI:`SDCR_CFG_PD0_LO];
         channel_powerdown_select[1] <= cmd_wdata[`SDCR_CFG_PD1_HI:`SDCR_CFG_PD1_LO];
      end
   end

   // lock and unlock sequence; the password stays armed until the next lock-bit or trigger write
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         register_write_lock <= 1'b0;
         unlock_armed <= 1'b0;
      end else if (soft_rst) begin
         register_write_lock <= 1'b0;
         unlock_armed <= 1'b0;
      end else if (wr_trig) begin
         unlock_armed <= cmd_wdata[`SDCR_TRG_UNLOCK_HI:`SDCR_TRG_UNLOCK_LO]
            == `SDCR_UNLOCK_CODE;
      end else if (wr_shared) begin
         unlock_armed <= 1'b0;
         if (!register_write_lock) begin
            register_write_lock <= cmd_wdata[`SDCR_CFG_LOCK];
         end else if (unlock_armed && !cmd_wdata[`SDCR_CFG_LOCK]) begin
            register_write_lock <= 1'b0;
         end
      end
   end

   // trigger register: password field is stored, action bits self-clear after one cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         unlock_password_field <= 4'h0;
         store_settings_trigger <= 1'b0;
         restore_settings_trigger <= 1'b0;
         soft_reset_pulse <= 1'b0;
      end else if (soft_rst) begin
         unlock_password_field <= 4'h0;
         store_settings_trigger <= 1'b0;
         restore_settings_trigger <= 1'b0;
         soft_reset_pulse <= 1'b0;
      end else begin
         store_settings_trigger <= wr_ok && wr_trig && cmd_wdata[`SDCR_TRG_STORE];
         restore_settings_trigger <= wr_ok && wr_trig && cmd_wdata[`SDCR_TRG_RESTORE];
         soft_reset_pulse <= wr_ok && wr_trig
            && cmd_wdata[`SDCR_TRG_SRST_HI:`SDCR_TRG_SRST_LO] == `SDCR_SRST_CODE;
         if (wr_trig) begin
            unlock_password_field <= cmd_wdata[`SDCR_TRG_UNLOCK_HI:`SDCR_TRG_UNLOCK_LO];
         end
      end
   end

   assign store_settings_pulse = store_settings_trigger;
   assign restore_settings_pulse = restore_settings_trigger;

   // nonvolatile copy survives the soft reset, so it only loads on store
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         nvm_ch[0] <= `SDCR_RST_CH;
         nvm_ch[1] <= `SDCR_RST_CH;
         nvm_shared <= `SDCR_RST_SHARED_CFG;
      end else if (store_settings_trigger) begin
         nvm_ch[0] <= ch_cfg[0];
         nvm_ch[1] <= ch_cfg[1];
         nvm_shared <= shared_rd;
      end
   end

   always_comb begin
      shared_rd = `SDCR_CFG_FIXED;
      shared_rd[`SDCR_CFG_LOCK] = register_write_lock;
      shared_rd[`SDCR_CFG_INTREF] = internal_ref_on;
      shared_rd[`SDCR_CFG_PD0_HI:`SDCR_CFG_PD0_LO] = channel_powerdown_select[0];
      shared_rd[`SDCR_CFG_PD1_HI:`SDCR_CFG_PD1_LO] = channel_powerdown_select[1];
      trig_rd = `SDCR_RST_TRIGGER;
      trig_rd[`SDCR_TRG_UNLOCK_HI:`SDCR_TRG_UNLOCK_LO] = unlock_password_field;
      trig_rd[`SDCR_TRG_STORE] = store_settings_trigger;
      trig_rd[`SDCR_TRG_RESTORE] = restore_settings_trigger;
   end

   // read: word latched at the request, then sent high byte then low byte
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_state <= SDCR_RD_IDLE;
         rd_word <= 16'h0000;
         rd_valid <= 1'b0;
         rd_last <= 1'b0;
         rd_byte <= 8'h00;
      end else begin
         case (rd_state)
            SDCR_RD_IDLE: begin
               rd_valid <= 1'b0;
               rd_last <= 1'b0;
               if (cmd_rd) begin
                  rd_state <= SDCR_RD_MSB;
                  case (cmd_addr)
                     `SDCR_ADDR_NOOP: rd_word <= noop_reg;
                     `SDCR_ADDR_CH0: rd_word <= ch_cfg[0];
                     `SDCR_ADDR_CH1: rd_word <= ch_cfg[1];
                     `SDCR_ADDR_SHARED_CFG: rd_word <= shared_rd;
                     `SDCR_ADDR_TRIGGER: rd_word <= trig_rd;
                     default: rd_word <= 16'h0000;
                  endcase
               end
            end
            SDCR_RD_MSB: begin
               rd_valid <= 1'b1;
               rd_byte <= rd_word[15:8];
               rd_state <= SDCR_RD_LSB;
            end
            SDCR_RD_LSB: begin
               rd_byte <= rd_word[7:0];
               rd_last <= 1'b1;
               rd_state <= SDCR_RD_IDLE;
            end
            default: begin
               rd_state <= SDCR_RD_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   locked_noop_hold_a: assert property (register_write_lock && !soft_rst |=>
      $stable(noop_reg))
      else $error("no-operation register changed while locked");
   locked_channel_hold_a: assert property (register_write_lock && !soft_rst
      && !restore_settings_trigger |=> ch_cfg[0] == $past(ch_cfg[0]))
      else $error("channel register changed while locked");
   unlock_needs_code_a: assert property ($fell(register_write_lock) && !$past(soft_rst)
      |-> $past(unlock_armed))
      else $error("lock released without the password");
   srst_one_cycle_a: assert property (soft_reset_pulse |=> !soft_reset_pulse
      && channel_powerdown_select == 4'hf)
      else $error("soft reset not self-clearing or power-down not restored");
   store_copies_a: assert property (store_settings_trigger |=> nvm_ch[1] == $past(ch_cfg[1]))
      else $error("store did not copy channel settings");
   restore_loads_a: assert property (restore_settings_trigger && !soft_rst |=>
      ch_cfg[0] == $past(nvm_ch[0]) && !restore_settings_trigger)
      else $error("restore did not load channel settings");
   read_byte_order_a: assert property (rd_state == SDCR_RD_MSB |=> rd_valid && !rd_last
      && rd_byte == rd_word[15:8] ##1 rd_valid && rd_last && rd_byte == rd_word[7:0])
      else $error("read bytes out of order");
   noop_reset_zero_a: assert property ($past(soft_rst) |-> noop_reg == 16'h0000)
      else $error("no-operation register not cleared by soft reset");
endmodule : sdcr_top

// ==== dv/sdcr_host.sv ====
// host controller model driving the command port of the register bank
`timescale 1ns/100ps
module sdcr_host (
   input wire logic sys_clk,
   input wire logic rd_valid,
   input wire logic rd_last,
   input wire logic [7:0] rd_byte,
   output logic cmd_wr,
   output logic cmd_rd,
   output logic [7:0] cmd_addr,
   output logic [15:0] cmd_wdata
);
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_addr = 8'hff;
      cmd_wdata = 16'ha5a5;
   end

   // callers pass reserved bits at their fixed values, don't-care bits at will
   task automatic wr(input logic [7:0] addr, input logic [15:0] data);
      @(posedge sys_clk);
      cmd_wr <= 1'b1;
      cmd_addr <= addr;
      cmd_wdata <= data;
      @(posedge sys_clk);
      cmd_wr <= 1'b0;
      // released lines show the inverse so stale values never look valid
      cmd_addr <= ~addr;
      cmd_wdata <= ~data;
   endtask : wr

   // latency is fixed by the command port, so no polling is needed
   task automatic rd(input logic [7:0] addr, output logic [15:0] word, output logic ok);
      @(posedge sys_clk);
      cmd_rd <= 1'b1;
      cmd_addr <= addr;
      @(posedge sys_clk);
      cmd_rd <= 1'b0;
      cmd_addr <= ~addr;
      // high byte stands one edge after the taking edge
      @(posedge sys_clk);
      #1;
      ok = (rd_valid === 1'b1) && (rd_last === 1'b0);
      word[15:8] = rd_byte;
      @(posedge sys_clk);
      #1;
      ok = ok && (rd_valid === 1'b1) && (rd_last === 1'b1);
      word[7:0] = rd_byte;
      @(posedge sys_clk);
      #1;
      ok = ok && (rd_valid === 1'b0);
   endtask : rd
endmodule : sdcr_host

// ==== dv/smart_dac_config_trigger_regs_test.sv ====
// self-checking bench for the configuration and trigger register bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module smart_dac_config_trigger_regs_test;
   import sdcr_pkg::*;
   logic sys_clk;
   logic rst_b;
   logic cmd_wr, cmd_rd, rd_valid, rd_last, internal_ref_on, register_write_lock;
   logic [7:0] cmd_addr, rd_byte;
   logic [15:0] cmd_wdata;
   logic [1:0][2:0] output_scale_select;
   logic [1:0] comparator_pin_opendrain, comparator_pin_route, trigger_input_divider_select;
   logic [1:0] comparator_polarity_invert, comparator_mode_on, gain_code_invalid;
   logic [1:0][1:0] channel_powerdown_select;
   logic soft_reset_pulse, store_settings_pulse, restore_settings_pulse;
   int error_cnt, tests_run, soft_n, store_n, rest_n;
   logic [4:0] lows [8] = '{5'h19, 5'h11, 5'h18, 5'h09, 5'h1f, 5'h04, 5'h02, 5'h00};

   sdcr_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_last(rd_last),
      .rd_byte(rd_byte), .output_scale_select(output_scale_select),
      .comparator_pin_opendrain(comparator_pin_opendrain),
      .comparator_pin_route(comparator_pin_route),
      .trigger_input_divider_select(trigger_input_divider_select),
      .comparator_polarity_invert(comparator_polarity_invert),
      .comparator_mode_on(comparator_mode_on), .gain_code_invalid(gain_code_invalid),
      .channel_powerdown_select(channel_powerdown_select), .internal_ref_on(internal_ref_on),
      .register_write_lock(register_write_lock), .soft_reset_pulse(soft_reset_pulse),
      .store_settings_pulse(store_settings_pulse),
      .restore_settings_pulse(restore_settings_pulse));

   sdcr_host host (.sys_clk(sys_clk), .rd_valid(rd_valid), .rd_last(rd_last),
      .rd_byte(rd_byte), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // a pulse that stretches shows up as an extra count
   always @(posedge sys_clk) begin
      if (soft_reset_pulse === 1'b1)
         soft_n++;
      if (store_settings_pulse === 1'b1)
         store_n++;
      if (restore_settings_pulse === 1'b1)
         rest_n++;
   end

   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] w;
      logic ok;
      host.rd(a, w, ok);
      `CHK("read framing", 1'b1, ok)
      `CHK("read word", exp, w)
   endtask : chk_rd

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   initial begin
      logic [15:0] d;
      logic [7:0] a;
      logic [2:0] g;
      logic [4:0] lo;
      logic ch;
      int n0;
      rst_b = 1'b0;
      error_cnt = 0;
      tests_run = 0;
      soft_n = 0;
      store_n = 0;
      rest_n = 0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      #1;
      `CHK("powerdown", 4'hf, channel_powerdown_select)
      chk_rd(8'h00, 16'h0000);
      chk_rd(8'h15, 16'h0000);
      chk_rd(8'h03, 16'h0000);
      chk_rd(8'h1f, 16'h0fff);
      chk_rd(8'h20, 16'h0000);
      chk_rd(8'h21, 16'h0000);
      $display("test reset_values done");
      host.wr(8'h00, 16'hffff);
      settle();
      `CHK("powerdown", 4'hf, channel_powerdown_select)
      chk_rd(8'h1f, 16'h0fff);
      chk_rd(8'h00, 16'hffff);
      $display("test noop done");
      // channels stay powered down and the internal reference comes first
      host.wr(8'h1f, 16'h1fff);
      settle();
      `CHK("internal ref", 1'b1, internal_ref_on)
      for (int i = 0; i < 16; i++) begin
         ch = i[0];
         g = i[3:1];
         lo = lows[g];
         a = ch ? 8'h03 : 8'h15;
         host.wr(a, {3'h7, g, 5'h1f, lo});
         settle();
         `CHK("scale", g, output_scale_select[ch])
         `CHK("invalid", (g > 3'h5), gain_code_invalid[ch])
         `CHK("opendrain", lo[4] & lo[3] & lo[0], comparator_pin_opendrain[ch])
         `CHK("route", lo[3], comparator_pin_route[ch])
         `CHK("divider", lo[2], trigger_input_divider_select[ch])
         `CHK("invert", lo[1], comparator_polarity_invert[ch])
         `CHK("mode", lo[0], comparator_mode_on[ch])
         chk_rd(a, {3'h0, g, 5'h00, lo});
      end
      $display("test channel_fields done");
      for (int p = 0; p < 16; p++) begin
         d = 16'h13f9 | (16'(p[3:2]) << 10) | (16'(p[1:0]) << 1);
         host.wr(8'h1f, d);
         settle();
         `CHK("powerdown", {p[1:0], p[3:2]}, channel_powerdown_select)
         chk_rd(8'h1f, d);
      end
      $display("test powerdown_codes done");
      host.wr(8'h15, 16'h0808);
      host.wr(8'h1f, 16'h5fff);
      settle();
      `CHK("lock", 1'b1, register_write_lock)
      host.wr(8'h15, 16'h0019);
      host.wr(8'h20, 16'h0002);
      settle();
      chk_rd(8'h15, 16'h0808);
      `CHK("store count", 0, store_n)
      // wrong password must leave the lock set
      host.wr(8'h20, 16'h6000);
      host.wr(8'h1f, 16'h1fff);
      settle();
      `CHK("lock", 1'b1, register_write_lock)
      host.wr(8'h20, 16'h5000);
      host.wr(8'h1f, 16'h1fff);
      settle();
      `CHK("lock", 1'b0, register_write_lock)
      $display("test lock done");
      n0 = store_n;
      host.wr(8'h20, 16'h0002);
      settle();
      `CHK("store count", n0 + 1, store_n)
      chk_rd(8'h20, 16'h0000);
      host.wr(8'h15, 16'h0000);
      host.wr(8'h20, 16'h0001);
      settle();
      `CHK("restore count", 1, rest_n)
      chk_rd(8'h15, 16'h0808);
      chk_rd(8'h20, 16'h0000);
      $display("test store_restore done");
      host.wr(8'h20, 16'h0b00);
      settle();
      `CHK("soft count", 0, soft_n)
      host.wr(8'h20, 16'h0a00);
      settle();
      `CHK("soft count", 1, soft_n)
      `CHK("internal ref", 1'b0, internal_ref_on)
      `CHK("powerdown", 4'hf, channel_powerdown_select)
      chk_rd(8'h15, 16'h0000);
      chk_rd(8'h1f, 16'h0fff);
      chk_rd(8'h20, 16'h0000);
      // the stored copy survives a soft reset
      host.wr(8'h20, 16'h0001);
      settle();
      chk_rd(8'h15, 16'h0808);
      $display("test soft_reset done");
      results();
   end
endmodule : smart_dac_config_trigger_regs_test
